/* File: design/dual_aux_pwm_generator.sv */
// two auxiliary pwm generators with independent and offset modes behind an apb slave
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "aux_pwm_map.svh"
module dual_aux_pwm_generator
    import aux_pwm_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        main_pwm_sync_pulse,
    input  wire logic        gpioOutEight,
    input  wire logic        gpioOutSeven,
    output logic             aux_out_zero,
    output logic             aux_out_one,
    output logic             port_pin_eight,
    output logic             port_pin_seven,
    output logic             pinEightPeripheral,
    output logic             pinSevenPeripheral
);

    initial
    begin
        if (WIDTH != 16)
            $error("dual_aux_pwm_generator: register map is built for 16-bit timers");
    end

    typedef struct packed {
        logic [15:0] aux_period_zero;
        logic [15:0] aux_period_or_offset_one;
        logic [15:0] aux_ontime_zero;
        logic [15:0] aux_ontime_one;
        logic [15:0] mode_control_reg;
        logic [15:0] pin_function_select;
        logic        half;
        logic        restart;
        logic [31:0] rdata;
    } regs_t;

    regs_t r;
    regs_t next_r;

    logic access;
    logic writeHit;
    logic independent;
    logic startZero;
    logic out0;
    logic out1;
    logic tick;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `OFS_PERIOD_ZERO) || (a == `OFS_PERIOD_ONE) || (a == `OFS_ONTIME_ZERO)
              || (a == `OFS_ONTIME_ONE) || (a == `OFS_MODE_CONTROL) || (a == `OFS_PIN_SELECT)
              || (a == `OFS_STATUS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // zero-wait slave: every access completes in its first access cycle
    assign access = psel && penable;
    assign writeHit = access && pwrite;
    assign pready = 1'b1;
    assign pslverr = access && !mapped(paddr);
    assign prdata = r.rdata;
    assign independent = r.mode_control_reg[`MODE_INDEP_BIT];
    assign tick = r.half;

    always_comb
    begin
        next_r = r;
        next_r.restart = 1'b0;
        // one step per two clocks; restart realigns the step
        next_r.half = r.restart ? 1'b0 : !r.half;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `OFS_PERIOD_ZERO:  next_r.rdata = {16'h0000, r.aux_period_zero};
                `OFS_PERIOD_ONE:   next_r.rdata = {16'h0000, r.aux_period_or_offset_one};
                `OFS_ONTIME_ZERO:  next_r.rdata = {16'h0000, r.aux_ontime_zero};
                `OFS_ONTIME_ONE:   next_r.rdata = {16'h0000, r.aux_ontime_one};
                `OFS_MODE_CONTROL: next_r.rdata = {16'h0000, r.mode_control_reg};
                `OFS_PIN_SELECT:   next_r.rdata = {16'h0000, r.pin_function_select};
                `OFS_STATUS:       next_r.rdata = {30'h00000000, out1, out0};
                default:           next_r.rdata = 32'h00000000;
            endcase
        end
        if (writeHit)
        begin
            case (paddr)
                `OFS_PERIOD_ZERO:
                begin
                    next_r.aux_period_zero = pwdata[15:0];
                    next_r.restart = 1'b1;
                end
                `OFS_PERIOD_ONE:
                begin
                    next_r.aux_period_or_offset_one = pwdata[15:0];
                    next_r.restart = 1'b1;
                end
                `OFS_ONTIME_ZERO:  next_r.aux_ontime_zero = pwdata[15:0];
                `OFS_ONTIME_ONE:   next_r.aux_ontime_one = pwdata[15:0];
                `OFS_MODE_CONTROL:
                begin
                    next_r.mode_control_reg = pwdata[15:0];
                    // mode change restarts both cycles so offset phase is defined
                    next_r.restart = 1'b1;
                end
                `OFS_PIN_SELECT:   next_r.pin_function_select = pwdata[15:0];
                default:           next_r.restart = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r.aux_period_zero          <= `RST_PERIOD;
            r.aux_period_or_offset_one <= `RST_PERIOD;
            r.aux_ontime_zero          <= `RST_ONTIME;
            r.aux_ontime_one           <= `RST_ONTIME;
            r.mode_control_reg         <= `RST_MODE;
            r.pin_function_select      <= `RST_PIN_SELECT;
            r.half                     <= 1'b0;
            r.restart                  <= 1'b0;
            r.rdata                    <= 32'h00000000;
        end
        else
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    aux_pwm_channel #(
        .WIDTH (WIDTH)
    ) chanZero (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .tick        (tick),
        .restart     (r.restart),
        .useDelay    (1'b0),
        .delay       ('0),
        .extStart    (1'b0),
        .useExtStart (1'b0),
        .period      (r.aux_period_zero),
        .onTime      (r.aux_ontime_zero),
        .pwmOut      (out0),
        .cycleStart  (startZero)
    );

    // offset mode: shared period from channel zero, delayed start
    // independent mode: own period register
    aux_pwm_channel #(
        .WIDTH (WIDTH)
    ) chanOne (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .tick        (tick),
        .restart     (r.restart || (!independent && startZero)),
        .useDelay    (!independent),
        .delay       (r.aux_period_or_offset_one),
        .extStart    (1'b0),
        .useExtStart (1'b0),
        .period      (independent ? r.aux_period_or_offset_one : r.aux_period_zero),
        .onTime      (r.aux_ontime_one),
        .pwmOut      (out1),
        .cycleStart  ()
    );
    // offset below the period is left to software; a larger one never rises

    assign aux_out_zero = out0;
    assign aux_out_one = out1;

    ////////////////////////////////////////////////////////////////////////
    // pin muxing: clear select bit gives the peripheral; bit 15/14 pick alternate
    assign pinEightPeripheral = !r.pin_function_select[`SEL_PIN8_BIT];
    assign pinSevenPeripheral = !r.pin_function_select[`SEL_PIN7_BIT];
    assign port_pin_eight = pinEightPeripheral
        ? (r.pin_function_select[`SEL_PIN8_ALT2_BIT] ? sys_clk : out0) : gpioOutEight;
    assign port_pin_seven = pinSevenPeripheral
        ? (r.pin_function_select[`SEL_PIN7_ALT2_BIT] ? main_pwm_sync_pulse : out1) : gpioOutSeven;

    ////////////////////////////////////////////////////////////////////////
    mode_follows_bit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        writeHit && paddr == `OFS_MODE_CONTROL |=> independent == $past(pwdata[`MODE_INDEP_BIT]))
        else $error("mode bit not taken");
    period_restart_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        writeHit && (paddr == `OFS_PERIOD_ZERO || paddr == `OFS_PERIOD_ONE) |=> r.restart)
        else $error("period write did not restart");
    ontime_no_glitch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        writeHit && paddr == `OFS_ONTIME_ZERO && !startZero && !r.restart
        |=> startZero || $stable(chanZero.cur.onLatch))
        else $error("on-time applied mid cycle");
    pin8_gpio_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        r.pin_function_select[`SEL_PIN8_BIT] |-> port_pin_eight == gpioOutEight)
        else $error("pin eight not gpio");
    pin7_aux_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !r.pin_function_select[`SEL_PIN7_BIT] && !r.pin_function_select[`SEL_PIN7_ALT2_BIT]
        |-> port_pin_seven == out1)
        else $error("pin seven not carrying second output");
    sync_alt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !r.pin_function_select[`SEL_PIN7_BIT] && r.pin_function_select[`SEL_PIN7_ALT2_BIT]
        |-> port_pin_seven == main_pwm_sync_pulse)
        else $error("pin seven not carrying sync");
    pin8_aux_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !r.pin_function_select[`SEL_PIN8_BIT] && !r.pin_function_select[`SEL_PIN8_ALT2_BIT]
        |-> port_pin_eight == out0)
        else $error("pin eight not carrying first output");
    pin7_gpio_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        r.pin_function_select[`SEL_PIN7_BIT] |-> port_pin_seven == gpioOutSeven)
        else $error("pin seven not gpio");
    step_two_clk_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tick && !r.restart |=> !tick)
        else $error("step not two clocks");
    full_duty_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        independent && r.aux_ontime_zero > r.aux_period_zero && startZero
        && $stable(r.aux_ontime_zero) |=> out0 [*8])
        else $error("full duty not held");
    offset_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !independent && startZero && r.aux_ontime_one != 16'h0000
        && r.aux_period_or_offset_one == 16'h0000 && !writeHit |-> ##[1:4] out1)
        else $error("second output did not rise after offset");

    cov_offset_c: cover property (@(posedge sys_clk) !independent && $rose(out1));
    cov_indep_c: cover property (@(posedge sys_clk) independent && $rose(out0));
    cov_restart_c: cover property (@(posedge sys_clk) r.restart);
    cov_full_duty_c: cover property (@(posedge sys_clk)
        independent && r.aux_ontime_zero > r.aux_period_zero && startZero);
    cov_second_fn_c: cover property (@(posedge sys_clk)
        !r.pin_function_select[`SEL_PIN7_BIT] && r.pin_function_select[`SEL_PIN7_ALT2_BIT]);

endmodule // dual_aux_pwm_generator

/* File: design/aux_pwm_map.svh */
// register offsets, field positions, reset values and timing constants of the auxiliary pwm block
`ifndef AUX_PWM_MAP_SVH
`define AUX_PWM_MAP_SVH

`define OFS_PERIOD_ZERO     12'h000
`define OFS_PERIOD_ONE      12'h004
`define OFS_ONTIME_ZERO     12'h008
`define OFS_ONTIME_ONE      12'h00C
`define OFS_MODE_CONTROL    12'h010
`define OFS_PIN_SELECT      12'h014
`define OFS_STATUS          12'h018

`define MODE_INDEP_BIT      8
`define SEL_PIN7_BIT        7
`define SEL_PIN8_BIT        8
`define SEL_PIN7_ALT2_BIT   14
`define SEL_PIN8_ALT2_BIT   15

`define RST_PERIOD          16'hFFFF
`define RST_ONTIME          16'h0000
`define RST_MODE            16'h0000
`define RST_PIN_SELECT      16'hFFFF

`define STEP_CLOCKS         2

`endif

/* File: design/aux_pwm_pkg.sv */
// types shared by the auxiliary pwm block
package aux_pwm_pkg;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_WAIT,
        CH_RUN
    } ch_state_t;

endpackage

/* File: design/aux_pwm_channel.sv */
// one auxiliary pwm channel: period counter, optional start delay, on-time latch
`timescale 1ns/1ns
`include "aux_pwm_map.svh"
module aux_pwm_channel
    import aux_pwm_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             tick,
    input  wire logic             restart,
    input  wire logic             useDelay,
    input  wire logic [WIDTH-1:0] delay,
    input  wire logic             extStart,
    input  wire logic             useExtStart,
    input  wire logic [WIDTH-1:0] period,
    input  wire logic [WIDTH-1:0] onTime,
    output logic                  pwmOut,
    output logic                  cycleStart
);

    initial
    begin
        if (WIDTH < 2 || WIDTH > 32)
            $error("aux_pwm_channel: WIDTH out of range");
    end

    typedef struct packed {
        ch_state_t        state;
        logic [WIDTH-1:0] count;
        logic [WIDTH-1:0] onLatch;
        logic             out;
        logic             start;
    } chan_t;

    chan_t cur;
    chan_t next_cur;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cur = cur;
        next_cur.start = 1'b0;
        if (restart)
        begin
            // counter cleared; cycle restarts right away unless useDelay or useExtStart holds it back
            next_cur.count = '0;
            next_cur.out = 1'b0;
            next_cur.state = useDelay ? CH_WAIT : (useExtStart ? CH_IDLE : CH_RUN);
            if (!useDelay && !useExtStart)
            begin
                next_cur.onLatch = onTime;
                next_cur.out = (onTime != '0);
                next_cur.start = 1'b1;
            end
        end
        else if (tick)
        begin
            case (cur.state)
                CH_IDLE:
                begin
                    next_cur.out = 1'b0;
                end
                CH_WAIT:
                begin
                    // offset delay of (delay+1) steps
                    if (cur.count == delay)
                    begin
                        next_cur.count = '0;
                        next_cur.state = CH_RUN;
                        next_cur.onLatch = onTime;
                        next_cur.out = (onTime != '0);
                        next_cur.start = 1'b1;
                    end
                    else
                        next_cur.count = cur.count + 1'b1;
                end
                CH_RUN:
                begin
                    if ((useExtStart && extStart) || (!useExtStart && cur.count == period))
                    begin
                        // period of (period+1) steps
                        next_cur.count = '0;
                        next_cur.onLatch = onTime;    // new on-time only at cycle start
                        next_cur.out = (onTime != '0);
                        next_cur.start = 1'b1;
                    end
                    else
                    begin
                        next_cur.count = cur.count + 1'b1;
                        // high for onLatch steps; over-period on-time stays high
                        next_cur.out = (cur.count + 1'b1 < cur.onLatch);
                    end
                end
                default:
                begin
                    next_cur.state = CH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            cur <= '{state: CH_RUN, count: '0, onLatch: '0, out: 1'b0, start: 1'b0};
        else
            cur <= next_cur;
    end

    assign pwmOut = cur.out;
    assign cycleStart = cur.start;

    ////////////////////////////////////////////////////////////////////////
    // a cycle start may load a fresh on-time, so only cycles that keep the zero latch are checked
    zero_on_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cur.state == CH_RUN && cur.onLatch == '0 && !next_cur.start) |=> !cur.out)
        else $error("output high with zero on-time");
    latch_at_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !$stable(cur.onLatch) |-> cur.start)
        else $error("on-time latch moved outside cycle start");
    restart_clears_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        restart |=> cur.count == '0)
        else $error("restart left counter running");
    wait_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cur.state == CH_WAIT |-> !cur.out)
        else $error("output high during offset delay");

endmodule // aux_pwm_channel

/* File: verif/aux_load_model.sv */
// pin-side load model: measures pulse widths, periods and offset on the two aux pins
`timescale 1ns/1ns
module aux_load_model (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        pinA,
    input  wire logic        pinB,
    output logic [31:0]      riseA,
    output logic [31:0]      highA,
    output logic [31:0]      perA,
    output logic [31:0]      highB,
    output logic [31:0]      perB,
    output logic [31:0]      offB
);
    logic [31:0] cyc;
    logic [31:0] tA;
    logic [31:0] tB;
    logic        lastA;
    logic        lastB;
    // a filter only sees levels, so every figure is taken from edges between two samples
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {cyc, tA, tB, riseA, highA, perA, highB, perB, offB} <= '0;
            {lastA, lastB} <= 2'b00;
        end
        else
        begin
            cyc   <= cyc + 1;
            lastA <= pinA;
            lastB <= pinB;
            if (pinA && !lastA)
            begin
                riseA <= riseA + 1;
                perA  <= cyc - tA;
                tA    <= cyc;
            end
            if (!pinA && lastA) highA <= cyc - tA;
            if (pinB && !lastB)
            begin
                perB <= cyc - tB;
                tB   <= cyc;
                offB <= cyc - tA;
            end
            if (!pinB && lastB) highB <= cyc - tB;
        end
    end
endmodule // aux_load_model

/* File: verif/dual_aux_pwm_generator_bench.sv */
// self-checking bench for the dual auxiliary pwm generator
`timescale 1ns/1ns
`include "aux_pwm_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module dual_aux_pwm_generator_bench
    import aux_pwm_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset_n, psel, penable, pwrite, pready, pslverr, syncIn, gpioE, gpioS;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        er, auxZ, auxO, pinE, pinS, perE, perS;
    logic [31:0] riseA, highA, perA, highB, perB, offB;
    int          n_errors = 0;
    int          compares = 0;
    int          p0, p1, o0, o1, off, n;
    logic [11:0] ofs [6] = '{`OFS_PERIOD_ZERO, `OFS_PERIOD_ONE, `OFS_ONTIME_ZERO, `OFS_ONTIME_ONE,
                             `OFS_MODE_CONTROL, `OFS_PIN_SELECT};
    logic [31:0] rst [6] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0, 32'h0, 32'h0, 32'h0000FFFF};

    always #10 sys_clk = ~sys_clk;

    dual_aux_pwm_generator dual_aux_pwm_generator_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .main_pwm_sync_pulse(syncIn), .gpioOutEight(gpioE),
        .gpioOutSeven(gpioS), .aux_out_zero(auxZ), .aux_out_one(auxO), .port_pin_eight(pinE),
        .port_pin_seven(pinS), .pinEightPeripheral(perE), .pinSevenPeripheral(perS));
    aux_load_model aux_load_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .pinA(pinE), .pinB(pinS),
        .riseA(riseA), .highA(highA), .perA(perA), .highB(highB), .perB(perB), .offB(offB));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin n_errors++; stop_test(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input int d);
        apb(1'b1, a, {16'h0000, 16'(d)});
    endtask

    // waits for the next rise on pin eight, n returns the cycles spent
    task automatic waitRise();
        logic [31:0] s;
        s = riseA;
        n = 0;
        while (riseA == s && n < 3000) begin @(posedge sys_clk); n++; end
        if (n >= 3000) begin n_errors++; stop_test(); end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, psel, penable, pwrite, syncIn, gpioE, gpioS} = '0;
        paddr = '0; pwdata = '0;
        void'($urandom(56728));
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (ofs[i]) begin apb(1'b0, ofs[i], 32'h0); `CHK({rd, er}, {rst[i], 1'b0}) end
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h00000000)
        gpioE <= 1'($urandom); gpioS <= 1'($urandom);
        @(posedge sys_clk); @(posedge sys_clk);
        `CHK({pinE, pinS, perE}, {gpioE, gpioS, 1'b0})
        $display("test reset done");
        wr(`OFS_PIN_SELECT, 16'h3E7F);
        // the write lands at the edge the task returns on, so let it settle first
        @(posedge sys_clk);
        `CHK({perE, perS}, 2'b11)
        for (int i = 0; i < 3; i++) begin
            p0 = $urandom_range(3, 40); p1 = $urandom_range(3, 40);
            o0 = $urandom_range(1, p0); o1 = $urandom_range(1, p1);
            wr(`OFS_MODE_CONTROL, 16'h0100); wr(`OFS_PERIOD_ZERO, p0); wr(`OFS_PERIOD_ONE, p1);
            wr(`OFS_ONTIME_ZERO, o0); wr(`OFS_ONTIME_ONE, o1);
            repeat (250) @(posedge sys_clk);
            `CHK({perA, perB}, {32'(2 * (p0 + 1)), 32'(2 * (p1 + 1))})
            `CHK({highA, highB}, {32'(2 * o0), 32'(2 * o1)})
            `CHK({auxZ, auxO}, {pinE, pinS})
        end
        $display("test independent done");
        // boundary: on-time one above the period must give a flat high
        wr(`OFS_ONTIME_ZERO, p0 + 1);
        repeat (100) @(posedge sys_clk);
        for (int k = 0; k < 90; k++) begin @(posedge sys_clk); `CHK(pinE, 1'b1) end
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK({rd[0], er}, 2'b10)
        wr(`OFS_PERIOD_ZERO, 20); wr(`OFS_ONTIME_ZERO, 5);
        waitRise(); waitRise(); waitRise();
        repeat (15) @(posedge sys_clk);
        wr(`OFS_PERIOD_ZERO, 20);
        waitRise();
        `CHK(n <= 8, 1'b1)
        wr(`OFS_ONTIME_ZERO, 15);
        waitRise();
        `CHK(highA, 32'd10)
        waitRise(); waitRise();
        `CHK(highA, 32'd30)
        $display("test update done");
        for (int i = 0; i < 3; i++) begin
            // first pass uses the smallest offset, the corner the offset start check watches
            p0 = $urandom_range(10, 40); off = (i == 0) ? 0 : $urandom_range(2, p0 - 2);
            wr(`OFS_MODE_CONTROL, 16'h0000); wr(`OFS_PERIOD_ZERO, p0); wr(`OFS_PERIOD_ONE, off);
            wr(`OFS_ONTIME_ZERO, $urandom_range(1, 5)); wr(`OFS_ONTIME_ONE, $urandom_range(1, 5));
            repeat (260) @(posedge sys_clk);
            `CHK({perA, perB}, {2{32'(2 * (p0 + 1))}})
            `CHK(offB + 2 >= 2 * (off + 1) && offB <= 2 * (off + 1) + 2, 1'b1)
        end
        $display("test offset done");
        wr(`OFS_PIN_SELECT, 16'hFE7F);
        for (int k = 0; k < 4; k++) begin
            syncIn <= 1'($urandom);
            @(negedge sys_clk);
            `CHK({pinS, pinE}, {syncIn, 1'b0})
            @(posedge sys_clk);
        end
        $display("test second function done");
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end
endmodule // dual_aux_pwm_generator_bench
